/* hw/wip_core.sv */
// wake input states, pulsed interrupt line and power sync sequencer
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1 - wake above high threshold: bias on, state one
// RULE2 - wake below digital low threshold: state zero
// RULE3 - bias off: both analog-low and in standby
// RULE4 - wake levels accepted only after filter time
// RULE5 - unmasked interrupt event gives one output pulse
// RULE6 - interrupt pulse lasts 100 us
// RULE7 - per-source inhibit bit suppresses the pulse
// RULE8 - seventeen main-logic interrupt sources
// RULE9 - six fail-safe monitor interrupt sources
// RULE10 - sync needs enable; select twin or external
// RULE11 - twin mode: wait line before pre-regulator start
// RULE12 - external mode: wait power good after pre-regulator
// RULE13 - power-down waits for external device first
// RULE14 - pre-regulator off delay 250 us or 32 ms
// RULE15 - sync line level filtered before use
module wip_core
	import wip_pkg::*;
#(
	parameter int WAKE_FILT     = WAKE_FILT_CYC,
	parameter int PULSE_LEN     = INT_PULSE_CYC,
	parameter int OFF_SHORT     = PREREG_OFF_CYC,
	parameter int OFF_LONG      = PREREG_OFF_LONG_CYC
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_b,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0]     avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	output var  logic [31:0]           avs_readdata,
	output var  logic                  avs_waitrequest,
	output var  logic                  irq,
	// wake comparators, bit 0 wake_input_a, bit 1 wake_input_b
	input  wire logic [1:0]            wake_above_high,
	input  wire logic [1:0]            wake_below_low,
	input  wire logic [1:0]            wake_below_analog,
	input  wire logic                  standby_in,
	output var  logic [1:0]            wake_state,
	output var  logic                  bias_enable,
	// interrupt sources
	input  wire logic [ANA_SRC_N-1:0]  ana_event_in,
	input  wire logic                  com_error_in,
	input  wire logic [FS_SRC_N-1:0]   fs_event_in,
	// open-drain interrupt pin
	output var  logic                  interrupt_pulse_out_dat,
	output var  logic                  interrupt_pulse_out_oe_b,
	// sequencer
	input  wire logic                  power_up_req,
	input  wire logic                  power_down_req,
	output var  logic                  pre_regulator_enable,
	output var  logic                  power_up_resume,
	// open-drain power sync pin
	input  wire logic                  power_sync_line_in,
	output var  logic                  power_sync_line_dat,
	output var  logic                  power_sync_line_oe_b
);

	logic [CFG_W-1:0]      cfg_r;
	logic [MAIN_SRC_N-1:0] main_flag_r;
	logic [MAIN_SRC_N-1:0] main_mask_r;
	logic [FS_SRC_N-1:0]   fs_flag_r;
	logic [FS_SRC_N-1:0]   fs_mask_r;
	logic                  ack_r;
	logic                  wr_en;
	logic [1:0]            wake_raw_r;
	logic [1:0]            wake_chg;
	logic [MAIN_SRC_N-1:0] main_ev;
	logic                  new_evt;
	logic                  pend_r;
	logic [PULSE_CNT_W-1:0] pcnt_r;
	logic                  sync_filt;
	logic                  sync_en;
	logic                  sync_ext;
	wip_seq_type           state_r;
	wip_seq_type           state_nxt;
	logic [OFF_CNT_W-1:0]  off_cnt_r;
	logic [OFF_CNT_W-1:0]  off_last;
	logic [31:0]           rd_nxt;

	assign sync_en  = cfg_r[CFG_SYNC_EN_BIT];
	assign sync_ext = cfg_r[CFG_PARTNER_BIT];

	// ********************************************************
	// avalon slave: one wait cycle per access
	// ********************************************************
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_en           = avs_write & ack_r;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end

	always_comb begin
		rd_nxt = 32'h0;
		if (avs_address == REG_CONFIG) begin
			rd_nxt[CFG_W-1:0] = cfg_r;
		end else if (avs_address == REG_STATUS) begin
			rd_nxt[STAT_WAKE_LSB +: 2] = wake_state;
			rd_nxt[STAT_BIAS_BIT]      = bias_enable;
			rd_nxt[STAT_SYNC_BIT]      = sync_filt;
			rd_nxt[STAT_PREREG_BIT]    = pre_regulator_enable;
			rd_nxt[STAT_SEQ_LSB +: 6]  = state_r;
		end else if (avs_address == REG_MAIN_FLAG) begin
			rd_nxt[MAIN_SRC_N-1:0] = main_flag_r;
		end else if (avs_address == REG_MAIN_MASK) begin
			rd_nxt[MAIN_SRC_N-1:0] = main_mask_r;
		end else if (avs_address == REG_FS_FLAG) begin
			rd_nxt[FS_SRC_N-1:0] = fs_flag_r;
		end else if (avs_address == REG_FS_MASK) begin
			rd_nxt[FS_SRC_N-1:0] = fs_mask_r;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0;
		end else if (avs_read & ~ack_r) begin
			avs_readdata <= rd_nxt;
		end
	end

	// ********************************************************
	// configuration and masks
	// ********************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cfg_r       <= CFG_RESET;
			main_mask_r <= MAIN_MASK_RESET;
			fs_mask_r   <= FS_MASK_RESET;
		end else if (wr_en) begin
			if (avs_address == REG_CONFIG) begin
				cfg_r <= avs_writedata[CFG_W-1:0]; // see RULE10
			end else if (avs_address == REG_MAIN_MASK) begin
				main_mask_r <= avs_writedata[MAIN_SRC_N-1:0]; // see RULE7
			end else if (avs_address == REG_FS_MASK) begin
				fs_mask_r <= avs_writedata[FS_SRC_N-1:0]; // see RULE7
			end
		end
	end

	// ********************************************************
	// wake inputs
	// ********************************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_wake
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					wake_raw_r[gi] <= 1'b0;
				end else if (wake_above_high[gi]) begin
					wake_raw_r[gi] <= 1'b1; // see RULE1
				end else if (wake_below_low[gi]) begin
					wake_raw_r[gi] <= 1'b0; // see RULE2
				end
			end

			wip_stable_filter #(.STABLE_CYC(WAKE_FILT)) u_wake_filt (
				.clk_sys  (clk_sys),
				.rst_b    (rst_b),
				.raw_in   (wake_raw_r[gi]), // see RULE4
				.filt_out (wake_state[gi]),
				.changed  (wake_chg[gi])
			);

			chk_wake_high : assert property (@(posedge clk_sys) disable iff (!rst_b)
				wake_above_high[gi] |=> wake_raw_r[gi]) // see RULE1
				else $error("wake level above high threshold not seen as one");
			chk_wake_low : assert property (@(posedge clk_sys) disable iff (!rst_b)
				(wake_below_low[gi] && !wake_above_high[gi]) |=> !wake_raw_r[gi]) // see RULE2
				else $error("wake level below low threshold not seen as zero");
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			bias_enable <= 1'b0;
		end else if (|wake_above_high) begin
			bias_enable <= 1'b1; // see RULE1
		end else if ((&wake_below_analog) && standby_in) begin
			bias_enable <= 1'b0; // see RULE3
		end
	end

	chk_bias_start : assert property (@(posedge clk_sys) disable iff (!rst_b)
		(|wake_above_high) |=> bias_enable) // see RULE1
		else $error("bias not started by a high wake input");
	chk_bias_stop : assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(bias_enable) |-> $past(&wake_below_analog) && $past(standby_in)) // see RULE3
		else $error("bias stopped outside standby or with a wake input up");

	// ********************************************************
	// interrupt flags, irq and pulse
	// ********************************************************
	assign main_ev = {com_error_in, wake_chg, ana_event_in}; // see RULE8
	assign new_evt = (|(main_ev & ~main_mask_r)) | (|(fs_event_in & ~fs_mask_r)); // see RULE7

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			main_flag_r <= '0;
			fs_flag_r   <= '0;
		end else begin
			if (wr_en && avs_address == REG_MAIN_FLAG) begin
				main_flag_r <= (main_flag_r & ~avs_writedata[MAIN_SRC_N-1:0]) | main_ev;
			end else begin
				main_flag_r <= main_flag_r | main_ev; // see RULE8
			end
			if (wr_en && avs_address == REG_FS_FLAG) begin
				fs_flag_r <= (fs_flag_r & ~avs_writedata[FS_SRC_N-1:0]) | fs_event_in;
			end else begin
				fs_flag_r <= fs_flag_r | fs_event_in; // see RULE9
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= (|(main_flag_r & ~main_mask_r)) | (|(fs_flag_r & ~fs_mask_r));
		end
	end

	assign interrupt_pulse_out_dat = 1'b0;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pend_r                   <= 1'b0;
			pcnt_r                   <= '0;
			interrupt_pulse_out_oe_b <= 1'b1;
		end else begin
			pend_r <= new_evt | (pend_r & ~interrupt_pulse_out_oe_b);
			if (interrupt_pulse_out_oe_b) begin
				if (pend_r) begin
					interrupt_pulse_out_oe_b <= 1'b0; // see RULE5
					pcnt_r                   <= '0;
				end
			end else if (pcnt_r == PULSE_CNT_W'(PULSE_LEN - 1)) begin
				interrupt_pulse_out_oe_b <= 1'b1; // see RULE6
			end else begin
				pcnt_r <= pcnt_r + PULSE_CNT_W'(1);
			end
		end
	end

	logic [PULSE_CNT_W-1:0] low_len_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			low_len_r <= '0;
		end else if (interrupt_pulse_out_oe_b) begin
			low_len_r <= '0;
		end else begin
			low_len_r <= low_len_r + PULSE_CNT_W'(1);
		end
	end

	chk_pulse_len : assert property (@(posedge clk_sys) disable iff (!rst_b)
		$rose(interrupt_pulse_out_oe_b) |-> low_len_r == PULSE_CNT_W'(PULSE_LEN)) // see RULE6
		else $error("interrupt pulse length wrong");
	chk_pulse_cause : assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(interrupt_pulse_out_oe_b) |-> $past(pend_r)) // see RULE5
		else $error("interrupt pulse without a pending event");
	chk_event_pulses : assert property (@(posedge clk_sys) disable iff (!rst_b)
		(new_evt && interrupt_pulse_out_oe_b) |-> ##2 !interrupt_pulse_out_oe_b) // see RULE5
		else $error("unmasked event did not start a pulse");
	chk_mask_blocks : assert property (@(posedge clk_sys) disable iff (!rst_b)
		(!pend_r && interrupt_pulse_out_oe_b && !(|(main_ev & ~main_mask_r)) &&
		!(|(fs_event_in & ~fs_mask_r))) |=> !pend_r ##1 interrupt_pulse_out_oe_b) // see RULE7
		else $error("pulse started for an inhibited source");

	// ********************************************************
	// power sync sequencer
	// ********************************************************
	wip_stable_filter #(.STABLE_CYC(SYNC_FILT_CYC)) u_sync_filt (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.raw_in   (power_sync_line_in), // see RULE15
		.filt_out (sync_filt),
		.changed  ()
	);

	assign off_last = cfg_r[CFG_OFF_DLY_BIT] ? OFF_CNT_W'(OFF_LONG - 1) : OFF_CNT_W'(OFF_SHORT - 1);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SEQ_IDLE: begin
				if (power_up_req) begin
					if (sync_en && !sync_ext) begin
						state_nxt = SEQ_WAIT_PART; // see RULE11
					end else begin
						state_nxt = SEQ_PREREG_UP;
					end
				end
			end
			SEQ_WAIT_PART: begin
				if (power_down_req) begin
					state_nxt = SEQ_IDLE;
				end else if (sync_filt) begin
					state_nxt = SEQ_PREREG_UP; // see RULE11
				end
			end
			SEQ_PREREG_UP: begin
				if (power_down_req) begin
					state_nxt = SEQ_OFF_DLY;
				end else if (!(sync_en && sync_ext) || sync_filt) begin
					state_nxt = SEQ_RUN; // see RULE12
				end
			end
			SEQ_RUN: begin
				if (power_down_req) begin
					state_nxt = (sync_en && sync_ext) ? SEQ_WAIT_EXT : SEQ_OFF_DLY;
				end
			end
			SEQ_WAIT_EXT: begin
				if (!sync_filt) begin
					state_nxt = SEQ_OFF_DLY; // see RULE13
				end
			end
			SEQ_OFF_DLY: begin
				if (off_cnt_r == off_last) begin
					state_nxt = SEQ_IDLE; // see RULE14
				end
			end
			default: state_nxt = SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= SEQ_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			off_cnt_r <= '0;
		end else if (state_r != SEQ_OFF_DLY) begin
			off_cnt_r <= '0;
		end else begin
			off_cnt_r <= off_cnt_r + OFF_CNT_W'(1); // see RULE14
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pre_regulator_enable <= 1'b0;
			power_up_resume      <= 1'b0;
			power_sync_line_oe_b <= 1'b1;
		end else begin
			pre_regulator_enable <= (state_nxt != SEQ_IDLE) && (state_nxt != SEQ_WAIT_PART);
			power_up_resume      <= (state_nxt == SEQ_RUN);
			// twin mode: hold the shared line low while not ready
			power_sync_line_oe_b <= !(sync_en && !sync_ext &&
				(state_nxt == SEQ_IDLE || state_nxt == SEQ_OFF_DLY)); // see RULE11
		end
	end

	assign power_sync_line_dat = 1'b0;

	sequence s_partner_wait;
		state_r == SEQ_WAIT_PART && !sync_filt;
	endsequence

	sequence s_ext_hold;
		state_r == SEQ_PREREG_UP && sync_en && sync_ext && !sync_filt && !power_down_req;
	endsequence

	chk_twin_wait : assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_partner_wait |=> !pre_regulator_enable) // see RULE11
		else $error("pre-regulator started before twin ready");
	chk_ext_hold : assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_ext_hold |=> pre_regulator_enable && !power_up_resume) // see RULE12
		else $error("power-up resumed before partner power good");
	chk_sync_off : assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_r == SEQ_IDLE && power_up_req && !sync_en) |=> state_r == SEQ_PREREG_UP ##1 state_r == SEQ_RUN) // see RULE10
		else $error("disabled sync still held the sequence");
	chk_ext_down : assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_r == SEQ_WAIT_EXT && sync_filt) |=> pre_regulator_enable) // see RULE13
		else $error("pre-regulator dropped before partner power-down");

	logic [OFF_CNT_W-1:0] off_len_r;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			off_len_r <= '0;
		end else if (state_r == SEQ_OFF_DLY) begin
			off_len_r <= off_len_r + OFF_CNT_W'(1);
		end else begin
			off_len_r <= '0;
		end
	end

	chk_off_delay : assert property (@(posedge clk_sys) disable iff (!rst_b)
		(state_r == SEQ_OFF_DLY && state_nxt == SEQ_IDLE) |->
		off_len_r == (cfg_r[CFG_OFF_DLY_BIT] ? OFF_CNT_W'(OFF_LONG - 1) : OFF_CNT_W'(OFF_SHORT - 1))) // see RULE14
		else $error("pre-regulator off delay wrong");
	chk_bus_answer : assert property (@(posedge clk_sys) disable iff (!rst_b)
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
		else $error("bus access not answered in one cycle");

endmodule // wip_core
`default_nettype wire

/* hw/wip_pkg.sv */
// constants, register map and types for the wake, interrupt and power sync block
package wip_pkg;

	// ********************************************************
	// clock and timing
	// ********************************************************
	localparam int CLK_MHZ           = 200;
	localparam int WAKE_FILT_US      = 70;
	localparam int INT_PULSE_US      = 100;
	localparam int SYNC_FILT_US      = 10;
	localparam int PREREG_OFF_US     = 250;
	localparam int PREREG_OFF_LONG_MS = 32;
	localparam int WAKE_FILT_CYC     = WAKE_FILT_US * CLK_MHZ;
	localparam int INT_PULSE_CYC     = INT_PULSE_US * CLK_MHZ;
	localparam int SYNC_FILT_CYC     = SYNC_FILT_US * CLK_MHZ;
	localparam int PREREG_OFF_CYC    = PREREG_OFF_US * CLK_MHZ;
	localparam int PREREG_OFF_LONG_CYC = PREREG_OFF_LONG_MS * 1000 * CLK_MHZ;
	localparam int OFF_CNT_W         = 23;
	localparam int PULSE_CNT_W       = 16;

	// ********************************************************
	// register map (byte addresses)
	// ********************************************************
	localparam int          ADDR_W        = 5;
	localparam logic [4:0]  REG_CONFIG    = 5'h00;
	localparam logic [4:0]  REG_STATUS    = 5'h04;
	localparam logic [4:0]  REG_MAIN_FLAG = 5'h08;
	localparam logic [4:0]  REG_MAIN_MASK = 5'h0c;
	localparam logic [4:0]  REG_FS_FLAG   = 5'h10;
	localparam logic [4:0]  REG_FS_MASK   = 5'h14;

	// config fields
	localparam int CFG_SYNC_EN_BIT   = 0;
	localparam int CFG_PARTNER_BIT   = 1;
	localparam int CFG_OFF_DLY_BIT   = 2;
	localparam int CFG_W             = 3;
	localparam logic [2:0] CFG_RESET = 3'h0;

	// interrupt source layout
	localparam int MAIN_SRC_N    = 17;
	localparam int ANA_SRC_N     = 14;
	localparam int WAKE_A_SRC    = 14;
	localparam int WAKE_B_SRC    = 15;
	localparam int COM_SRC       = 16;
	localparam int FS_SRC_N      = 6;
	localparam logic [16:0] MAIN_MASK_RESET = 17'h00000;
	localparam logic [5:0]  FS_MASK_RESET   = 6'h00;

	// status fields
	localparam int STAT_WAKE_LSB  = 0;
	localparam int STAT_BIAS_BIT  = 2;
	localparam int STAT_SYNC_BIT  = 3;
	localparam int STAT_PREREG_BIT = 4;
	localparam int STAT_SEQ_LSB   = 5;

	// ********************************************************
	// sequencer states
	// ********************************************************
	typedef enum logic [5:0] {
		SEQ_IDLE      = 6'h01,
		SEQ_WAIT_PART = 6'h02,
		SEQ_PREREG_UP = 6'h04,
		SEQ_RUN       = 6'h08,
		SEQ_WAIT_EXT  = 6'h10,
		SEQ_OFF_DLY   = 6'h20
	} wip_seq_type;

endpackage

/* hw/wip_stable_filter.sv */
// level filter that accepts a change only after it stays stable
`timescale 1ns/1ps
`default_nettype none

module wip_stable_filter
	import wip_pkg::*;
#(
	parameter int STABLE_CYC = SYNC_FILT_CYC
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// level in and filtered level out
	input  wire logic raw_in,
	output var  logic filt_out,
	output var  logic changed
);

	localparam int CW = $clog2(STABLE_CYC + 1);

	logic [CW-1:0] cnt_r;

	// ********************************************************
	// stability counter
	// ********************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r    <= '0;
			filt_out <= 1'b0;
			changed  <= 1'b0;
		end else begin
			changed <= 1'b0;
			if (raw_in == filt_out) begin
				cnt_r <= '0;
			end else if (cnt_r == CW'(STABLE_CYC - 1)) begin
				cnt_r    <= '0;
				filt_out <= raw_in;
				changed  <= 1'b1;
			end else begin
				cnt_r <= cnt_r + CW'(1);
			end
		end
	end

	chk_filter_stable : assert property (@(posedge clk_sys) disable iff (!rst_b)
		$changed(filt_out) |-> $past(cnt_r) == CW'(STABLE_CYC - 1)) // see RULE4
		else $error("filtered level changed before the stable time");

endmodule // wip_stable_filter
`default_nettype wire

/* testbench/wip_core_tb.sv */
// self-checking testbench for the wake, interrupt and power sync block
`timescale 1ns/1ps
`default_nettype none

module wip_core_tb
	import wip_pkg::*;
;
	localparam int PLEN = 16;
	logic        clk_sys = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  avs_address = 5'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic        avs_waitrequest, irq;
	logic [1:0]  wk_hi = 2'h0, wk_lo = 2'h3, wk_an = 2'h0, wake_state;
	logic        standby_in = 1'b0;
	logic        bias_enable;
	logic [20:0] ev = 21'h0;
	logic        int_dat, int_oe_b, prereg, resume;
	logic        up_req = 1'b0, down_req = 1'b0;
	logic        sync_in, sync_dat, sync_oe_b, peer_oe_b;
	logic        peer_ready = 1'b0;
	int          miscompares = 0, n_tests = 0, cyc = 0, n, k;

	always #2.5 clk_sys = ~clk_sys;
	// pulled-up wired-and line
	assign sync_in = (sync_oe_b | sync_dat) & peer_oe_b;

	wip_core #(.WAKE_FILT(20), .PULSE_LEN(PLEN), .OFF_SHORT(30), .OFF_LONG(60)) DUT (
		.clk_sys(clk_sys), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .irq(irq),
		.wake_above_high(wk_hi), .wake_below_low(wk_lo), .wake_below_analog(wk_an),
		.standby_in(standby_in), .wake_state(wake_state), .bias_enable(bias_enable),
		.ana_event_in(ev[13:0]), .com_error_in(ev[14]), .fs_event_in(ev[20:15]),
		.interrupt_pulse_out_dat(int_dat), .interrupt_pulse_out_oe_b(int_oe_b),
		.power_up_req(up_req), .power_down_req(down_req),
		.pre_regulator_enable(prereg), .power_up_resume(resume),
		.power_sync_line_in(sync_in), .power_sync_line_dat(sync_dat),
		.power_sync_line_oe_b(sync_oe_b));

	wip_partner_pmic #(.DLY(40)) u_peer (
		.clk_sys(clk_sys), .rst_b(rst_b), .ready(peer_ready), .line_oe_b(peer_oe_b));

	task automatic results;
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= ~wr;
		avs_writedata <= d;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic fire(input logic [20:0] v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= 21'h0;
	endtask

	task automatic pulse(output int len);
		len = 0;
		for (k = 0; k < 6 && int_oe_b !== 1'b0; k++) @(posedge clk_sys);
		while (int_oe_b === 1'b0 && len < 99) begin
			len++;
			@(posedge clk_sys);
		end
	endtask

	task automatic req(input logic dn);
		@(posedge clk_sys);
		if (dn) down_req <= 1'b1;
		else up_req <= 1'b1;
		@(posedge clk_sys);
		up_req   <= 1'b0;
		down_req <= 1'b0;
	endtask

	task automatic till_prereg(input logic v);
		for (n = 0; n < 3000 && prereg !== v; n++) @(posedge clk_sys);
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		for (int i = 0; i < 28; i += 4) rd(i[4:0], i == 4 ? 32'h20 : 32'h0);
		bus(1'b1, 5'h18, 32'hffffffff);
		rd(5'h18, 32'h0);
		for (int i = 0; i < 21; i++) begin
			fire(21'h1 << i);
			pulse(n);
			chk(n, PLEN);
			chk({irq, int_dat}, 2'h2);
			if (i < 15) rd(REG_MAIN_FLAG, i < 14 ? 32'h1 << i : 32'h10000);
			else rd(REG_FS_FLAG, 32'h1 << (i - 15));
			bus(1'b1, i < 15 ? REG_MAIN_FLAG : REG_FS_FLAG, q);
			repeat (2) @(posedge clk_sys);
			chk(irq, 0);
		end
		fire(21'h1);
		fire(21'h2);
		pulse(n);
		chk(n, PLEN);
		pulse(n);
		chk(n, PLEN);
		bus(1'b1, REG_MAIN_FLAG, 32'h3);
		bus(1'b1, REG_MAIN_MASK, 32'h1ffff);
		bus(1'b1, REG_FS_MASK, 32'h3f);
		fire(21'h8008);
		pulse(n);
		chk({n[7:0], irq}, 9'h0);
		rd(REG_MAIN_FLAG, 32'h8);
		bus(1'b1, REG_MAIN_FLAG, q);
		bus(1'b1, REG_FS_FLAG, 32'h1);
		bus(1'b1, REG_MAIN_MASK, 32'h0);
		bus(1'b1, REG_FS_MASK, 32'h0);
		for (int j = 0; j < 2; j++) begin
			wk_hi <= 2'h1 << j;
			wk_lo <= 2'h0;
			repeat (3) @(posedge clk_sys);
			chk(bias_enable, 1);
			repeat (7) @(posedge clk_sys);
			chk(wake_state, 0);
			repeat (20) @(posedge clk_sys);
			chk(wake_state, 2'h1 << j);
			rd(REG_MAIN_FLAG, 32'h4000 << j);
			wk_hi <= 2'h0;
			wk_lo <= 2'h3;
			repeat (30) @(posedge clk_sys);
			chk(wake_state, 0);
			bus(1'b1, REG_MAIN_FLAG, 32'h1ffff);
		end
		wk_an      <= 2'h1;
		standby_in <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(bias_enable, 1);
		wk_an      <= 2'h3;
		standby_in <= 1'b0;
		repeat (5) @(posedge clk_sys);
		chk(bias_enable, 1);
		standby_in <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(bias_enable, 0);
		req(1'b0);
		repeat (3) @(posedge clk_sys);
		chk({prereg, resume, sync_oe_b}, 3'h7);
		req(1'b1);
		repeat (27) @(posedge clk_sys);
		chk(prereg, 1);
		repeat (10) @(posedge clk_sys);
		chk(prereg, 0);
		bus(1'b1, REG_CONFIG, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk({sync_oe_b, sync_dat}, 2'h0);
		req(1'b0);
		repeat (2200) @(posedge clk_sys);
		chk({prereg, sync_oe_b}, 2'h1);
		peer_ready <= 1'b1;
		till_prereg(1'b1);
		chk(n > 2030 && n < 2100, 1);
		req(1'b1);
		repeat (40) @(posedge clk_sys);
		chk(prereg, 0);
		bus(1'b1, REG_CONFIG, 32'h7);
		peer_ready <= 1'b0;
		// let the filtered line settle low before the next power-up
		repeat (2100) @(posedge clk_sys);
		rd(REG_STATUS, 32'h20);
		req(1'b0);
		repeat (2200) @(posedge clk_sys);
		chk({prereg, resume, sync_oe_b}, 3'h5);
		peer_ready <= 1'b1;
		for (n = 0; n < 3000 && resume !== 1'b1; n++) @(posedge clk_sys);
		chk(n > 2030 && n < 2100, 1);
		peer_ready <= 1'b0;
		req(1'b1);
		till_prereg(1'b0);
		chk(n > 2055 && n < 2120, 1);
		results();
	end
endmodule // wip_core_tb

`default_nettype wire

/* testbench/wip_partner_pmic.sv */
// far-side power device model holding the shared sync line
`timescale 1ns/1ps
`default_nettype none

module wip_partner_pmic #(
	parameter int DLY = 40
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_b,
	// command and open-drain pin
	input  wire logic ready,
	output var  logic line_oe_b
);
	int cnt_r;

	// holds the line low until ready, then releases it DLY cycles after ready is first seen high
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r     <= 0;
			line_oe_b <= 1'b0;
		end else if (!ready) begin
			cnt_r     <= 0;
			line_oe_b <= 1'b0;
		end else if (cnt_r == DLY) begin
			line_oe_b <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1;
		end
	end
endmodule // wip_partner_pmic

`default_nettype wire
